// file: rtl/resizer_output_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "resizer_output_ctrl_regs.vh"

module resizer_output_ctrl (
  // Clock, enable and reset
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  // Avalon-MM slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Frame and line events from pipeline (same clock)
  input  wire        frame_sync_pulse,
  input  wire        line_done,
  input  wire        input_is_422,
  // Output steering
  output reg         path_active,
  output reg  [31:0] line_addr,
  output reg         luma_out_on,
  output reg         chroma_out_on,
  output reg         convert_420
);

  // =============================================
  // Registers
  reg [`CAP_W-1:0] chroma_line_capacity;    // Ring capacity
  reg              channel_b_enable;        // Path enable
  reg              single_pass_select;      // Pass mode
  reg              chroma_en_bit;           // Chroma enable field
  reg              luma_en_bit;             // Luma enable field
  reg [15:0]       first_hi;                // First address upper half
  reg [15:0]       first_lo;                // First address lower half
  reg [15:0]       line_pitch;              // Bytes per line slot
  reg              pass_done;               // Single pass finished
  reg              ack;                     // One wait cycle done
  reg              running;                 // Frame in progress
  wire [`CAP_W-1:0] slot;                   // Current ring slot
  wire [31:0]      region_first_addr;       // Assembled first address
  wire             access;                  // Read or write pending
  wire             wr_hit;                  // Write taken this edge
  wire [3:0]       word;                    // Word index
  wire [31:0]      slot_offset;             // Slot times pitch, full width

  // Operands widened first so the product is not cut to 16 bits
  assign slot_offset = {19'h00000, slot} * {16'h0000, line_pitch};

  assign region_first_addr = {first_hi, first_lo};
  assign access            = avs_read | avs_write;
  // One wait state: request taken on the edge where ack is high
  assign avs_waitrequest   = access & ~ack;
  assign wr_hit            = avs_write & ack & clk_en;
  assign word              = avs_address[5:2];

  // Full-word write only counts when the low lane is enabled
  function sel;
    input [3:0] a;
    input [3:0] want;
    begin
      sel = (a == want) & avs_byteenable[0];
    end
  endfunction

  // =============================================
  // Bus handshake
  // Ack pulses for one cycle so back-to-back requests each wait once
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= access & ~ack;
    end
  end

  // =============================================
  // Register writes
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chroma_line_capacity <= `CAP_RESET;
      single_pass_select   <= 1'b0;
      chroma_en_bit        <= 1'b0;
      luma_en_bit          <= 1'b0;
      first_hi             <= 16'h0000;
      first_lo             <= 16'h0000;
      line_pitch           <= 16'h0000;
    end else if (wr_hit) begin
      if (sel(word, `ADDR_CAPACITY)) begin
        chroma_line_capacity <= avs_writedata[`CAP_W-1:0];
      end
      if (sel(word, `ADDR_PASS_MODE)) begin
        single_pass_select <= avs_writedata[`SINGLE_PASS_BIT];
      end
      if (sel(word, `ADDR_SUBSAMPLE)) begin
        chroma_en_bit <= avs_writedata[`CHROMA_BIT];
        luma_en_bit   <= avs_writedata[`LUMA_BIT];
      end
      if (sel(word, `ADDR_FIRST_HI)) begin
        first_hi <= avs_writedata[15:0];
      end
      if (sel(word, `ADDR_FIRST_LO)) begin
        first_lo <= avs_writedata[15:0];
      end
      if (sel(word, `ADDR_PITCH)) begin
        // Low bits forced so pitch stays a 32-byte multiple
        line_pitch <= {avs_writedata[15:`PITCH_ZERO_BITS],
                       {`PITCH_ZERO_BITS{1'b0}}};
      end
    end
  end

  // =============================================
  // Enable bit and single-pass end
  // Hardware clear on frame sync wins over a same-cycle software set,
  // so a pass cannot silently restart on the edge that ended it.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_b_enable <= 1'b0;
      pass_done        <= 1'b0;
      running          <= 1'b0;
    end else if (clk_en) begin
      if (frame_sync_pulse & channel_b_enable & single_pass_select & running) begin
        channel_b_enable <= 1'b0;
        pass_done        <= 1'b1;
        running          <= 1'b0;
      end else begin
        if (wr_hit & sel(word, `ADDR_ENABLE)) begin
          channel_b_enable <= avs_writedata[`ENABLE_BIT];
          if (avs_writedata[`ENABLE_BIT]) begin
            pass_done <= 1'b0;
          end
        end
        // A frame starts only at sync while enabled
        if (frame_sync_pulse) begin
          running <= channel_b_enable;
        end else if (!channel_b_enable) begin
          running <= 1'b0;
        end
      end
    end
  end

  // =============================================
  // Line ring
  line_slot_ring u_ring (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .frame_start (frame_sync_pulse),
    .line_done   (line_done & running),
    .capacity    (chroma_line_capacity),
    .slot        (slot)
  );

  // =============================================
  // Output address and format steering
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_addr     <= 32'h00000000;
      path_active   <= 1'b0;
      luma_out_on   <= 1'b0;
      chroma_out_on <= 1'b0;
      convert_420   <= 1'b0;
    end else if (clk_en) begin
      // 13x16 product fits in 29 bits of the 32-bit offset
      line_addr   <= region_first_addr + slot_offset;
      path_active <= running;
      if (input_is_422 && (chroma_en_bit || luma_en_bit)) begin
        chroma_out_on <= chroma_en_bit;
        luma_out_on   <= luma_en_bit;
        convert_420   <= 1'b1;
      end else begin
        // Enables ignored off 4:2:2, or both low: plain 4:2:2 out
        chroma_out_on <= 1'b1;
        luma_out_on   <= 1'b1;
        convert_420   <= 1'b0;
      end
    end
  end

  // =============================================
  // Read data, reserved bits zero
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      if (avs_read & ~ack) begin
        case (word)
          `ADDR_CAPACITY:  avs_readdata <= {19'h00000, chroma_line_capacity};
          `ADDR_ENABLE:    avs_readdata <= {31'h00000000, channel_b_enable};
          `ADDR_PASS_MODE: avs_readdata <= {31'h00000000, single_pass_select};
          `ADDR_SUBSAMPLE: avs_readdata <= {30'h00000000, chroma_en_bit, luma_en_bit};
          `ADDR_FIRST_HI:  avs_readdata <= {16'h0000, first_hi};
          `ADDR_FIRST_LO:  avs_readdata <= {16'h0000, first_lo};
          `ADDR_PITCH:     avs_readdata <= {16'h0000, line_pitch};
          `ADDR_STATUS:    avs_readdata <= {16'h0000, pass_done, running, 1'b0, slot};
          default:         avs_readdata <= 32'h00000000;  // Unmapped reads zero
        endcase
      end
    end
  end

endmodule // resizer_output_ctrl
`default_nettype wire

// file: rtl/resizer_output_ctrl_regs.vh
`ifndef RESIZER_OUTPUT_CTRL_REGS_VH
`define RESIZER_OUTPUT_CTRL_REGS_VH

// =============================================
// Register word addresses
`define ADDR_CAPACITY    4'h0
`define ADDR_ENABLE      4'h1
`define ADDR_PASS_MODE   4'h2
`define ADDR_SUBSAMPLE   4'h3
`define ADDR_FIRST_HI    4'h4
`define ADDR_FIRST_LO    4'h5
`define ADDR_PITCH       4'h6
`define ADDR_STATUS      4'h7

// =============================================
// Field layout and reset values
`define CAP_W            13
`define CAP_RESET        13'h1fff
`define PITCH_ZERO_BITS  5
`define ENABLE_BIT       0
`define SINGLE_PASS_BIT  0
`define CHROMA_BIT       1
`define LUMA_BIT         0

`endif

// file: rtl/line_slot_ring.v
`timescale 1ns/10ps
`default_nettype none
`include "resizer_output_ctrl_regs.vh"

module line_slot_ring (
  // Clock and reset
  input  wire                  core_clk,
  input  wire                  reset_n,
  input  wire                  clk_en,
  // Control
  input  wire                  frame_start,
  input  wire                  line_done,
  input  wire [`CAP_W-1:0]     capacity,
  // Slot
  output reg  [`CAP_W-1:0]     slot
);

  // =============================================
  // Slot counter
  // At-or-above-capacity check: capacity 3 gives slots 0..3 then 0
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot <= {`CAP_W{1'b0}};
    end else if (clk_en) begin
      if (frame_start) begin
        slot <= {`CAP_W{1'b0}};
      end else if (line_done) begin
        if (slot >= capacity) begin
          slot <= {`CAP_W{1'b0}};
        end else begin
          slot <= slot + {{(`CAP_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // line_slot_ring
`default_nettype wire

// file: sim/resizer_output_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Bus and steering checks
module resizer_output_ctrl_props (
  // Clock, reset, bus
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pipeline and steering
  input wire logic        frame_sync_pulse,
  input wire logic        line_done,
  input wire logic        input_is_422,
  input wire logic        path_active,
  input wire logic [31:0] line_addr,
  input wire logic        luma_out_on,
  input wire logic        chroma_out_on,
  input wire logic        convert_420
);
  logic [1:0] quiet; // Edges since a slot or register event
  // Address may only move two edges after an event
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) quiet <= 2'h0;
    else if (line_done || frame_sync_pulse || avs_write) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("wait state count off");
  chk_idle_free: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait without request");
  chk_rsv_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address[5:2] inside {4'h1, 4'h2, 4'h3} |-> avs_readdata[31:2] == 30'h0)
    else $error("reserved bits not zero");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[5]
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_pitch_low: assert property (avs_read && !avs_waitrequest &&
    avs_address[5:2] == 4'h6 |-> avs_readdata[4:0] == 5'h0) else $error("pitch low bits set");
  chk_frame_gate: assert property (!path_active && !frame_sync_pulse &&
    !$past(frame_sync_pulse) |=> !path_active)
    else $error("frame began without sync");
  chk_plain_out: assert property ($past(reset_n) && !input_is_422 &&
    !$past(input_is_422) |-> !convert_420 && luma_out_on && chroma_out_on)
    else $error("enables acted on non 422 input");
  chk_both_off: assert property ($past(reset_n) && !convert_420 |->
    luma_out_on && chroma_out_on) else $error("plain output lost a component");
  chk_conv_some: assert property ($past(reset_n) && convert_420 |->
    luma_out_on || chroma_out_on) else $error("conversion with no output");
  chk_addr_hold: assert property (quiet == 2'h3 |-> $stable(line_addr))
    else $error("line address moved idle");
endmodule // resizer_output_ctrl_props
bind resizer_output_ctrl resizer_output_ctrl_props resizer_output_ctrl_props_inst (.core_clk,
  .reset_n, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .frame_sync_pulse, .line_done, .input_is_422, .path_active, .line_addr, .luma_out_on,
  .chroma_out_on, .convert_420);
`default_nettype wire

// file: sim/pipe_source_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Upstream pipeline: syncs, line strobes, format
module pipe_source_model (
  input  wire logic core_clk,
  input  wire logic want_422,
  output var  logic frame_sync_pulse = 1'b0,
  output var  logic line_done = 1'b0,
  output var  logic input_is_422 = 1'b0
);
  // Format is a level, one edge behind the bench
  always @(posedge core_clk) input_is_422 <= want_422;
  // One-cycle strobe, then a settle gap
  task automatic pulse(input logic sync, input int gap);
    if (sync) frame_sync_pulse <= 1'b1;
    else line_done <= 1'b1;
    @(posedge core_clk);
    frame_sync_pulse <= 1'b0;
    line_done <= 1'b0;
    repeat (gap) @(posedge core_clk);
  endtask
endmodule // pipe_source_model
`default_nettype wire

// file: sim/resizer_output_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "resizer_output_ctrl_regs.vh"
module resizer_output_ctrl_tb;
  logic core_clk = 1'b0, reset_n = 1'b0, want_422 = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic clk_en = 1'b1;
  logic [5:0] avs_address = 6'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, line_addr, q, base, pitch, cap;
  wire avs_waitrequest, frame_sync_pulse, line_done, input_is_422, path_active;
  wire luma_out_on, chroma_out_on, convert_420;
  int fail_count = 0, total_checks = 0;
  always #25 core_clk = ~core_clk;
  resizer_output_ctrl resizer_output_ctrl_inst (.core_clk, .reset_n, .clk_en, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .frame_sync_pulse, .line_done, .input_is_422, .path_active, .line_addr, .luma_out_on,
    .chroma_out_on, .convert_420);
  pipe_source_model pipe_source_model_inst (.core_clk, .want_422, .frame_sync_pulse, .line_done,
    .input_is_422);
  // ====
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low
  task automatic bus(input logic we, input logic [3:0] w, input logic [31:0] d);
    int n = 0;
    avs_write <= we;
    avs_read <= !we;
    avs_address <= {w, 2'b00};
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) fail_count++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] w, input logic [31:0] exp);
    bus(1'b0, w, 32'h0);
    chk(q, exp);
  endtask
  function automatic logic [31:0] ring_addr(logic [31:0] b, p, c, int n);
    return b + (32'(n) % (c + 32'h1)) * p;
  endfunction
  // Expected {luma, chroma, convert}
  function automatic logic [31:0] steer(logic [1:0] bits, logic fmt);
    return (!fmt || bits == 2'b00) ? 32'h6 : {29'h0, bits[0], bits[1], 1'b1};
  endfunction
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    wrap_up;
  end
  // ====
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    void'($urandom(32'hf2fe));
    @(posedge core_clk);
    rd(`ADDR_CAPACITY, 32'h1fff);
    rd(`ADDR_ENABLE, 32'h0);
    rd(`ADDR_PASS_MODE, 32'h0);
    rd(4'h8, 32'h0);
    // Ring wrap at the documented example, then random capacities
    // No RGB output here, so capacities need not be multiples of four
    for (int k = 0; k < 3; k++) begin
      cap = (k == 0) ? 32'h3 : 32'h1 + $urandom % 7;
      base = $urandom;
      pitch = {16'h0, 16'($urandom)};
      bus(1'b1, `ADDR_CAPACITY, cap);
      rd(`ADDR_CAPACITY, cap);
      bus(1'b1, `ADDR_FIRST_HI, {16'h0, base[31:16]});
      bus(1'b1, `ADDR_FIRST_LO, {16'h0, base[15:0]});
      bus(1'b1, `ADDR_PITCH, pitch);
      pitch[4:0] = 5'h0;
      rd(`ADDR_PITCH, pitch);
      bus(1'b1, `ADDR_ENABLE, 32'h1);
      pipe_source_model_inst.pulse(1'b1, 2);
      for (int n = 0; n <= 2 * cap + 3; n++) begin
        chk(line_addr, ring_addr(base, pitch, cap, n));
        pipe_source_model_inst.pulse(1'b0, 2 + $urandom % 3);
      end
    end
    // Clock enable low: a line strobe must not move the slot
    q = line_addr;
    clk_en <= 1'b0;
    pipe_source_model_inst.pulse(1'b0, 2);
    clk_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(line_addr, q);
    // Single pass: running frame ends, further syncs ignored until re-enabled
    bus(1'b1, `ADDR_PASS_MODE, 32'h1);
    rd(`ADDR_PASS_MODE, 32'h1);
    for (int s = 0; s < 4; s++) begin
      pipe_source_model_inst.pulse(1'b1, 2);
      chk({31'h0, path_active}, (s == 2) ? 32'h1 : 32'h0);
      rd(`ADDR_ENABLE, (s == 2) ? 32'h1 : 32'h0);
      if (s == 1) bus(1'b1, `ADDR_ENABLE, 32'h1);
    end
    // Every enable pair under both input formats
    for (int m = 0; m < 8; m++) begin
      want_422 <= m[2];
      bus(1'b1, `ADDR_SUBSAMPLE, {30'h0, m[1:0]});
      rd(`ADDR_SUBSAMPLE, {30'h0, m[1:0]});
      chk({29'h0, luma_out_on, chroma_out_on, convert_420}, steer(m[1:0], m[2]));
    end
    wrap_up;
  end
endmodule // resizer_output_ctrl_tb
`default_nettype wire
